// file: rtl/lamp_switch_timing_supervisor.sv
// Purpose: timing supervision of a four-channel protected lamp switch
// Assumes: pins pass two flip-flops
// Notes: analog parts live outside
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - four over-current profiles, seven steps each
// - cooling profiles, six steps each
// - slow cooling first 1668 ms, last 1796 ms
// - clock fail below about 2 kHz
// - clock fail above about 200 kHz
// - detector runs only with external PWM clock
// - output PWM frequency at most 1 kHz
// - uncalibrated internal PWM about 120 Hz
// - calibrated PWM within ten percent of target
// - calibration pulse between 20 and 200 us
// - duty of 0 and 100 percent supported
// - direct input toggle timeout 250 ms
// - watchdog expires 310 ms after reset release
// - fault flag asserted after 5 us blanking
// - output off 7 us after flag
// - sense valid 100 us after chip select
// - LED open-load check every 128 clocks
// - sample on falling, shift on rising edge
// - chip select rise loads received word
// - watchdog enabled while fail-safe input open
module lamp_switch_timing_supervisor import lamp_timing_pkg::*; #(
    parameter logic [25:0] TOGGLE_CYC = TOGGLE_CYC_DEF,
    parameter logic [25:0] WDOG_CYC = WDOG_CYC_DEF,
    parameter logic [16:0] CLKFAIL_LOW_CYC = CF_LOW_CYC,
    parameter logic [13:0] SENSE_CYC = SENSE_VALID_CYC,
    parameter logic [15:0] CAL_MAX = CAL_MAX_CYC,
    parameter logic [15:0] PWM_TICK_DEF = PWM_DEF_TICK_CYC
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [3:0] directCtrlIn,
    input wire logic chipSelN,
    input wire logic serialClk,
    input wire logic serialDataIn,
    input wire logic failsafeCfgIn,
    input wire logic [3:0] overTemperatureFault,
    input wire logic [3:0] overCurrentFault,
    input wire logic [3:0] shortCircuitFault,
    input wire logic [3:0] undervoltageFault,
    input wire logic [1:0] overcurrentProfileSel,
    input wire logic [1:0] coolingProfileSel,
    input wire logic pwmEnable,
    input wire logic clockSelect,
    input wire logic ledMode,
    input wire logic [3:0] outputCmd,
    input wire logic [3:0][7:0] pwmDuty,
    output logic [3:0] powerOutput,
    output logic faultFlagNOut,
    output logic faultFlagNOe,
    output logic serialDataOut,
    output logic serialDataOe,
    output logic [15:0] spiWord,
    output logic spiWordStrobe,
    output logic senseOutputValid,
    output logic clockFail,
    output logic watchdogExpired,
    output logic [3:0] inputTimeout,
    output logic openLoadStrobe,
    output logic calibrated,
    output logic [2:0] ocStep,
    output logic [2:0] coolStep
);

    typedef struct packed {
        logic [PIN_W-1:0] pinA;
        logic [PIN_W-1:0] pinB;
        logic [PIN_W-1:0] pinC;
        logic [10:0] stepTickCnt;
        logic stepTick;
        logic [15:0] spiShift;
        logic [4:0] bitCnt;
        logic [15:0] spiWord;
        logic spiStrobe;
        logic [15:0] soShift;
        logic soOe;
        logic [13:0] senseCnt;
        logic senseValid;
        logic [15:0] csLowCnt;
        logic [15:0] calTick;
        logic calibrated;
        logic [15:0] pwmTickCnt;
        logic [7:0] pwmCnt;
        logic [16:0] in0PerCnt;
        logic clockFail;
        logic [6:0] olCnt;
        logic openLoadStrobe;
        logic [3:0][25:0] togCnt;
        logic [3:0] inTimeout;
        logic [25:0] wdCnt;
        logic wdExpired;
        logic [3:0][9:0] blankCnt;
        logic [3:0][9:0] offCnt;
        logic [3:0] shutOff;
        logic faultFlag;
        logic coolSeen;
        logic ocStart;
        logic coolStart;
        logic [3:0] pwrOut;
    } sup_s;

    sup_s s_r;
    sup_s s_nxt;
    logic [PIN_W-1:0] rawPins;
    logic [3:0] dinB;
    logic csnB;
    logic in0Rise;
    logic csFall;
    logic csRise;
    logic sclkRise;
    logic sclkFall;
    logic wordDone;
    logic clockExt;
    logic [3:0] faultAny;
    logic [15:0] statusWord;
    logic [15:0] pwmLimit;

    step_if ocIf ();
    step_if coolIf ();

    assign rawPins = {undervoltageFault, shortCircuitFault, overCurrentFault, overTemperatureFault,
                      failsafeCfgIn, serialDataIn, serialClk, chipSelN, directCtrlIn};

    // edges are taken between the second and third stages only
    assign dinB = s_r.pinB[PIN_DIN_LSB +: 4];
    assign csnB = s_r.pinB[PIN_CSN];
    assign in0Rise = s_r.pinB[PIN_DIN_LSB] & ~s_r.pinC[PIN_DIN_LSB];
    assign csFall = ~s_r.pinB[PIN_CSN] & s_r.pinC[PIN_CSN];
    assign csRise = s_r.pinB[PIN_CSN] & ~s_r.pinC[PIN_CSN];
    assign sclkRise = s_r.pinB[PIN_SCLK] & ~s_r.pinC[PIN_SCLK];
    assign sclkFall = ~s_r.pinB[PIN_SCLK] & s_r.pinC[PIN_SCLK];
    assign wordDone = csRise & (s_r.bitCnt == SPI_BITS_LAST);
    assign clockExt = pwmEnable & ~clockSelect;
    assign faultAny = s_r.pinB[PIN_FLT_LSB +: 4] | s_r.pinB[PIN_FLT_LSB + 4 +: 4]
                    | s_r.pinB[PIN_FLT_LSB + 8 +: 4] | s_r.pinB[PIN_FLT_LSB + 12 +: 4];
    assign statusWord = {s_r.faultFlag, s_r.clockFail, s_r.wdExpired, s_r.calibrated,
                         s_r.inTimeout, s_r.shutOff, s_r.pwrOut};
    assign pwmLimit = s_r.calibrated ? s_r.calTick : PWM_TICK_DEF;

    always_comb begin
        s_nxt = s_r;
        s_nxt.pinA = rawPins;
        s_nxt.pinB = s_r.pinA;
        s_nxt.pinC = s_r.pinB;
        s_nxt.spiStrobe = 1'b0;
        s_nxt.stepTick = 1'b0;
        s_nxt.openLoadStrobe = 1'b0;
        s_nxt.ocStart = 1'b0;
        s_nxt.coolStart = 1'b0;

        // 10 us step time base
        if (s_r.stepTickCnt == STEP_TICK_CYC - 11'h1) begin
            s_nxt.stepTickCnt = '0;
            s_nxt.stepTick = 1'b1;
        end else begin
            s_nxt.stepTickCnt = s_r.stepTickCnt + 11'h1;
        end

        // serial port
        s_nxt.soOe = ~csnB;
        if (csFall) begin
            s_nxt.soShift = statusWord;
            s_nxt.bitCnt = '0;
        end else if (!csnB) begin
            if (sclkFall) begin
                s_nxt.spiShift = {s_r.spiShift[14:0], s_r.pinB[PIN_SDI]};
                if (s_r.bitCnt != SPI_BITS_LAST) begin
                    s_nxt.bitCnt = s_r.bitCnt + 5'h1;
                end
            end
            if (sclkRise && s_r.bitCnt != 5'h0) begin
                s_nxt.soShift = {s_r.soShift[14:0], 1'b0};
            end
        end
        if (wordDone) begin
            s_nxt.spiWord = s_r.spiShift;
            s_nxt.spiStrobe = 1'b1;
        end

        // sense settling after each chip select rise
        if (csRise) begin
            s_nxt.senseCnt = '0;
            s_nxt.senseValid = 1'b0;
        end else if (!s_r.senseValid) begin
            if (s_r.senseCnt == SENSE_CYC - 14'h1) begin
                s_nxt.senseValid = 1'b1;
            end else begin
                s_nxt.senseCnt = s_r.senseCnt + 14'h1;
            end
        end

        // calibration pulse measured on chip select low time
        if (csFall) begin
            s_nxt.csLowCnt = '0;
        end else if (!csnB && s_r.csLowCnt != 16'hFFFF) begin
            s_nxt.csLowCnt = s_r.csLowCnt + 16'h1;
        end
        if (csRise && s_r.csLowCnt >= CAL_MIN_CYC && s_r.csLowCnt <= CAL_MAX) begin
            s_nxt.calibrated = 1'b1;
            s_nxt.calTick = s_r.csLowCnt;
        end

        // pwm time base, 256 ticks per period keeps the rate under 1 kHz
        if (clockExt) begin
            if (in0Rise) begin
                s_nxt.pwmCnt = s_r.pwmCnt + 8'h1;
            end
        end else if (s_r.pwmTickCnt >= pwmLimit - 16'h1) begin
            s_nxt.pwmTickCnt = '0;
            s_nxt.pwmCnt = s_r.pwmCnt + 8'h1;
        end else begin
            s_nxt.pwmTickCnt = s_r.pwmTickCnt + 16'h1;
        end

        // external clock supervision
        if (!clockExt) begin
            s_nxt.in0PerCnt = '0;
            s_nxt.clockFail = 1'b0;
        end else if (in0Rise) begin
            s_nxt.in0PerCnt = '0;
            s_nxt.clockFail = (s_r.in0PerCnt < CF_HIGH_CYC);
        end else if (s_r.in0PerCnt >= CLKFAIL_LOW_CYC) begin
            s_nxt.clockFail = 1'b1;
        end else begin
            s_nxt.in0PerCnt = s_r.in0PerCnt + 17'h1;
        end

        // cyclic open-load check in LED mode
        if (ledMode && in0Rise) begin
            s_nxt.olCnt = s_r.olCnt + 7'h1;
            s_nxt.openLoadStrobe = (s_r.olCnt == OL_DIV_LAST);
        end

        // watchdog, restarted by each complete serial word
        if (!s_r.pinB[PIN_FSI]) begin
            s_nxt.wdCnt = '0;
            s_nxt.wdExpired = 1'b0;
        end else if (!s_r.wdExpired) begin
            if (wordDone) begin
                s_nxt.wdCnt = '0;
            end else if (s_r.wdCnt == WDOG_CYC - 26'h1) begin
                s_nxt.wdExpired = 1'b1;
            end else begin
                s_nxt.wdCnt = s_r.wdCnt + 26'h1;
            end
        end

        // cooling run done: retry channels whose fault is gone
        if (coolIf.busy) begin
            s_nxt.coolSeen = 1'b1;
        end else if (s_r.coolSeen) begin
            s_nxt.coolSeen = 1'b0;
            s_nxt.shutOff = s_r.shutOff & faultAny;
        end

        for (int i = 0; i < 4; i++) begin
            // toggle timeout per direct input
            if (dinB[i] != s_r.pinC[PIN_DIN_LSB + i]) begin
                s_nxt.togCnt[i] = '0;
                s_nxt.inTimeout[i] = 1'b0;
            end else if (s_r.togCnt[i] == TOGGLE_CYC - 26'h1) begin
                s_nxt.inTimeout[i] = 1'b1;
            end else begin
                s_nxt.togCnt[i] = s_r.togCnt[i] + 26'h1;
            end

            // fault blanking then delayed shutdown
            if (!faultAny[i]) begin
                s_nxt.blankCnt[i] = '0;
                s_nxt.offCnt[i] = '0;
            end else if (s_r.blankCnt[i] != FAULT_BLANK_CYC) begin
                s_nxt.blankCnt[i] = s_r.blankCnt[i] + 10'h1;
            end else if (!s_r.shutOff[i]) begin
                if (s_r.offCnt[i] == SHUTDOWN_CYC - 10'h1) begin
                    s_nxt.shutOff[i] = 1'b1;
                    s_nxt.coolStart = 1'b1;
                    s_nxt.offCnt[i] = '0;
                end else begin
                    s_nxt.offCnt[i] = s_r.offCnt[i] + 10'h1;
                end
            end

            // output select: fail-safe, pwm or plain command
            if (s_r.wdExpired) begin
                s_nxt.pwrOut[i] = dinB[i];
            end else if (pwmEnable) begin
                if (pwmDuty[i] == DUTY_OFF) begin
                    s_nxt.pwrOut[i] = 1'b0;
                end else if (pwmDuty[i] == DUTY_FULL) begin
                    s_nxt.pwrOut[i] = 1'b1;
                end else begin
                    s_nxt.pwrOut[i] = (s_r.pwmCnt < pwmDuty[i]);
                end
            end else begin
                s_nxt.pwrOut[i] = outputCmd[i];
            end
            if (s_r.shutOff[i] || (clockExt && s_r.clockFail)) begin
                s_nxt.pwrOut[i] = 1'b0;
            end
        end

        s_nxt.faultFlag = 1'b0;
        for (int i = 0; i < 4; i++) begin
            if (s_r.blankCnt[i] == FAULT_BLANK_CYC || s_r.shutOff[i]) begin
                s_nxt.faultFlag = 1'b1;
            end
        end
        if ((s_nxt.pwrOut & ~s_r.pwrOut) != 4'h0) begin
            s_nxt.ocStart = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign ocIf.start = s_r.ocStart;
    assign ocIf.profileSel = overcurrentProfileSel;
    assign ocIf.tick = s_r.stepTick;
    assign coolIf.start = s_r.coolStart;
    assign coolIf.profileSel = coolingProfileSel;
    assign coolIf.tick = s_r.stepTick;

    step_sequencer #(.COOLING(1'b0)) ocSeq (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .link(ocIf)
    );

    step_sequencer #(.COOLING(1'b1)) coolSeq (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .link(coolIf)
    );

    assign powerOutput = s_r.pwrOut;
    assign faultFlagNOut = 1'b0;
    assign faultFlagNOe = s_r.faultFlag;
    assign serialDataOut = s_r.soShift[15];
    assign serialDataOe = s_r.soOe;
    assign spiWord = s_r.spiWord;
    assign spiWordStrobe = s_r.spiStrobe;
    assign senseOutputValid = s_r.senseValid;
    assign clockFail = s_r.clockFail;
    assign watchdogExpired = s_r.wdExpired;
    assign inputTimeout = s_r.inTimeout;
    assign openLoadStrobe = s_r.openLoadStrobe;
    assign calibrated = s_r.calibrated;
    assign ocStep = ocIf.stepIdx;
    assign coolStep = coolIf.stepIdx;

endmodule : lamp_switch_timing_supervisor
`default_nettype wire

// file: rtl/lamp_timing_pkg.sv
// Purpose: shared constants
// Assumes: sys_clk at 125 MHz
// Notes: step tables are typical durations in 10 us ticks
package lamp_timing_pkg;

    localparam int CLK_HZ = 125_000_000;
    localparam int CLK_MHZ = 125;

    // pin bundle layout after synchronisation
    localparam int PIN_W = 24;
    localparam int PIN_DIN_LSB = 0;
    localparam int PIN_CSN = 4;
    localparam int PIN_SCLK = 5;
    localparam int PIN_SDI = 6;
    localparam int PIN_FSI = 7;
    localparam int PIN_FLT_LSB = 8;

    localparam int SPI_BITS = 16;
    localparam logic [4:0] SPI_BITS_LAST = 5'h10;

    localparam int FAULT_BLANK_NS = 5000;
    localparam logic [9:0] FAULT_BLANK_CYC = 10'(FAULT_BLANK_NS * CLK_MHZ / 1000);
    localparam int SHUTDOWN_NS = 7000;
    localparam logic [9:0] SHUTDOWN_CYC = 10'(SHUTDOWN_NS * CLK_MHZ / 1000);
    localparam int SENSE_VALID_US = 100;
    localparam logic [13:0] SENSE_VALID_CYC = 14'(SENSE_VALID_US * CLK_MHZ);
    localparam int CAL_MIN_US = 20;
    localparam logic [15:0] CAL_MIN_CYC = 16'(CAL_MIN_US * CLK_MHZ);
    localparam int CAL_MAX_US = 200;
    localparam logic [15:0] CAL_MAX_CYC = 16'(CAL_MAX_US * CLK_MHZ);
    localparam int STEP_TICK_US = 10;
    localparam logic [10:0] STEP_TICK_CYC = 11'(STEP_TICK_US * CLK_MHZ);
    localparam int CF_LOW_HZ = 2000;
    localparam logic [16:0] CF_LOW_CYC = 17'(CLK_HZ / CF_LOW_HZ);
    localparam int CF_HIGH_HZ = 200_000;
    localparam logic [16:0] CF_HIGH_CYC = 17'(CLK_HZ / CF_HIGH_HZ);
    localparam int PWM_DEF_HZ = 120;
    localparam int PWM_STEPS = 256;
    localparam logic [15:0] PWM_DEF_TICK_CYC = 16'(CLK_HZ / (PWM_DEF_HZ * PWM_STEPS));
    localparam logic [7:0] DUTY_OFF = 8'h00;
    localparam logic [7:0] DUTY_FULL = 8'hFF;
    localparam int TOGGLE_MS = 250;
    localparam logic [25:0] TOGGLE_CYC_DEF = 26'(TOGGLE_MS * (CLK_HZ / 1000));
    localparam int WDOG_MS = 310;
    localparam logic [25:0] WDOG_CYC_DEF = 26'(WDOG_MS * (CLK_HZ / 1000));
    localparam logic [6:0] OL_DIV_LAST = 7'h7F;

    localparam logic [1:0] OC_SLOW = 2'h0;
    localparam logic [1:0] OC_FAST = 2'h1;
    localparam logic [1:0] OC_MEDIUM = 2'h2;
    localparam logic [1:0] OC_VERY_SLOW = 2'h3;
    localparam logic [2:0] OC_LAST_STEP = 3'h6;
    localparam logic [2:0] COOL_LAST_STEP = 3'h5;

    typedef logic [17:0] step_t;

    // rows indexed by the profile code
    localparam step_t OC_STEP [4][7] = '{
        '{18'h1F4, 18'h0AC, 18'h0C8, 18'h12C, 18'h1F4, 18'h4C4, 18'h116C},
        '{18'h0F8, 18'h050, 18'h068, 18'h09E, 18'h0E0, 18'h264, 18'h08AC},
        '{18'h3D4, 18'h140, 18'h1A4, 18'h244, 18'h3D4, 18'h988, 18'h22D8},
        '{18'h7A8, 18'h280, 18'h348, 18'h488, 18'h7A8, 18'h1310, 18'h45B0}
    };
    localparam step_t COOL_STEP [4][7] = '{
        '{18'h145C8, 18'h0AF00, 18'h0C738, 18'h0E8D0, 18'h11878, 18'h15EC8, 18'h0},
        '{18'h0A348, 18'h05780, 18'h06338, 18'h07148, 18'h08CA0, 18'h0FD20, 18'h0},
        '{18'h28B90, 18'h15D38, 18'h18F38, 18'h1D1A0, 18'h23028, 18'h2BD90, 18'h0},
        '{18'h145C8, 18'h0AF00, 18'h0C738, 18'h0E8D0, 18'h11878, 18'h15EC8, 18'h0}
    };

endpackage : lamp_timing_pkg

// file: rtl/step_if.sv
// Purpose: supervisor to sequencer link
// Assumes: all signals on sys_clk
// Notes: start and tick are one-cycle pulses
`timescale 1ns/100ps
`default_nettype none
interface step_if;
    logic start;
    logic [1:0] profileSel;
    logic tick;
    logic [2:0] stepIdx;
    logic busy;
    modport seq (input start, input profileSel, input tick, output stepIdx, output busy);
    modport ctl (output start, output profileSel, output tick, input stepIdx, input busy);
endinterface : step_if
`default_nettype wire

// file: rtl/step_sequencer.sv
// Purpose: walks the step durations of one timing profile
// Assumes: tick is a 10 us enable pulse
// Notes: a new start restarts at step one
`timescale 1ns/100ps
`default_nettype none
module step_sequencer import lamp_timing_pkg::*; #(
    parameter bit COOLING = 1'b0
) (
    input wire logic sys_clk,
    input wire logic rstn,
    step_if.seq link
);

    typedef enum logic {SEQ_IDLE, SEQ_RUN} seq_e;
    typedef struct packed {
        seq_e state;
        logic [1:0] prof;
        logic [2:0] stepIdx;
        step_t cnt;
        logic busy;
    } seq_s;

    seq_s s_r;
    seq_s s_nxt;
    step_t dur;
    logic [2:0] lastStep;

    assign lastStep = COOLING ? COOL_LAST_STEP : OC_LAST_STEP;
    assign dur = COOLING ? COOL_STEP[s_r.prof][s_r.stepIdx] : OC_STEP[s_r.prof][s_r.stepIdx];

    always_comb begin
        s_nxt = s_r;
        case (s_r.state)
            SEQ_IDLE: begin
                s_nxt.busy = 1'b0;
            end
            SEQ_RUN: begin
                if (link.tick) begin
                    s_nxt.cnt = s_r.cnt + 18'h1;
                    if (s_r.cnt + 18'h1 >= dur) begin
                        s_nxt.cnt = '0;
                        if (s_r.stepIdx == lastStep) begin
                            s_nxt.state = SEQ_IDLE;
                            s_nxt.busy = 1'b0;
                            s_nxt.stepIdx = '0;
                        end else begin
                            s_nxt.stepIdx = s_r.stepIdx + 3'h1;
                        end
                    end
                end
            end
            default: begin
                s_nxt.state = SEQ_IDLE;
            end
        endcase
        if (link.start) begin
            s_nxt.state = SEQ_RUN;
            s_nxt.prof = link.profileSel;
            s_nxt.stepIdx = '0;
            s_nxt.cnt = '0;
            s_nxt.busy = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s_r <= '{state: SEQ_IDLE, prof: 2'h0, stepIdx: 3'h0, cnt: 18'h0, busy: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign link.stepIdx = s_r.stepIdx;
    assign link.busy = s_r.busy;

endmodule : step_sequencer
`default_nettype wire

// file: dv/lamp_switch_timing_supervisor_monitor.sv
// Purpose: port-level checks
// Assumes: counts from the bind
// Notes: helper counters measure spans
`timescale 1ns/100ps
`default_nettype none
module lamp_switch_timing_supervisor_monitor import lamp_timing_pkg::*; #(
    parameter logic [25:0] WDOG_CYC = WDOG_CYC_DEF,
    parameter logic [13:0] SENSE_CYC = SENSE_VALID_CYC
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic chipSelN,
    input wire logic failsafeCfgIn,
    input wire logic [3:0] overTemperatureFault,
    input wire logic [3:0] overCurrentFault,
    input wire logic [3:0] shortCircuitFault,
    input wire logic [3:0] undervoltageFault,
    input wire logic [3:0] powerOutput,
    input wire logic faultFlagNOe,
    input wire logic serialDataOe,
    input wire logic [15:0] spiWord,
    input wire logic spiWordStrobe,
    input wire logic senseOutputValid,
    input wire logic watchdogExpired,
    input wire logic openLoadStrobe
);
    logic [3:0] fltVec;
    logic [10:0] fltCnt_r, flgCnt_r;
    logic [13:0] senCnt_r;
    logic senArm_r;
    logic [25:0] wdCnt_r;
    assign fltVec = overTemperatureFault | overCurrentFault | shortCircuitFault | undervoltageFault;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            fltCnt_r <= 11'h0;
            flgCnt_r <= 11'h0;
            senCnt_r <= 14'h0;
            senArm_r <= 1'b0;
            wdCnt_r <= 26'h0;
        end else begin
            fltCnt_r <= (fltVec == 4'h0) ? 11'h0 : fltCnt_r + {10'h0, fltCnt_r != 11'h7FF};
            flgCnt_r <= !faultFlagNOe ? 11'h0 : flgCnt_r + {10'h0, flgCnt_r != 11'h7FF};
            senCnt_r <= senseOutputValid ? 14'h0 : senCnt_r + {13'h0, senCnt_r != 14'h3FFF};
            senArm_r <= senArm_r | senseOutputValid;
            wdCnt_r <= (spiWordStrobe || !failsafeCfgIn) ? 26'h0 : wdCnt_r + 26'h1;
        end
    end
    default clocking mcb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);
    a_word_on_strobe: assert property ($changed(spiWord) |-> spiWordStrobe)
        else $error("word changed without strobe");
    a_so_idle: assert property (chipSelN [*5] |-> !serialDataOe)
        else $error("serial out driven while deselected");
    a_sense_rise: assert property ($rose(senseOutputValid) && senArm_r |-> senCnt_r >= SENSE_CYC - 14'h2)
        else $error("sense valid too early");
    a_sense_bound: assert property (senArm_r && !senseOutputValid |-> senCnt_r <= SENSE_CYC + 14'h2)
        else $error("sense valid too late");
    a_flag_blank: assert property ($rose(faultFlagNOe) |-> fltCnt_r >= 11'h271)
        else $error("fault flag before blanking");
    a_flag_due: assert property (fltCnt_r == 11'h280 |-> faultFlagNOe)
        else $error("fault flag missing");
    a_shut_delay: assert property (flgCnt_r == 11'h37A |-> (powerOutput & fltVec) == 4'h0)
        else $error("faulty output still on");
    a_wdog_time: assert property ($rose(watchdogExpired) |-> wdCnt_r >= WDOG_CYC - 26'h2 && wdCnt_r <= WDOG_CYC + 26'h6)
        else $error("watchdog expiry off time");
    a_wdog_due: assert property (wdCnt_r == WDOG_CYC + 26'h8 |-> watchdogExpired)
        else $error("watchdog never expired");
    a_ol_pulse: assert property (openLoadStrobe |=> !openLoadStrobe)
        else $error("open load strobe too long");
endmodule : lamp_switch_timing_supervisor_monitor
bind lamp_switch_timing_supervisor lamp_switch_timing_supervisor_monitor #(
    .WDOG_CYC(WDOG_CYC), .SENSE_CYC(SENSE_CYC)
) mon (.*);
`default_nettype wire

// file: dv/host_mcu_model.sv
// Purpose: host serial frames and pwm clock
// Assumes: driven on the falling sys_clk edge
// Notes: clock stops when halfPer is 0
`timescale 1ns/100ps
`default_nettype none
module host_mcu_model (
    input wire logic sys_clk,
    output logic chipSelN,
    output logic serialClk,
    output logic serialDataIn,
    output logic extClk
);
    int halfPer = 0;
    int cnt = 0;
    initial begin
        chipSelN = 1'b1;
        serialClk = 1'b0;
        serialDataIn = 1'b0;
        extClk = 1'b0;
    end
    always @(negedge sys_clk) begin
        cnt <= (halfPer == 0 || cnt >= halfPer - 1) ? 0 : cnt + 1;
        if (halfPer == 0)
            extClk <= 1'b0;
        else if (cnt >= halfPer - 1)
            extClk <= ~extClk;
    end
    // sends the top n bits of w, msb first
    task automatic spi_xfer(input logic [15:0] w, input int n);
        @(negedge sys_clk) chipSelN <= 1'b0;
        repeat (8) @(negedge sys_clk);
        for (int i = 15; i > 15 - n; i--) begin
            serialClk <= 1'b1;
            serialDataIn <= w[i];
            repeat (8) @(negedge sys_clk);
            serialClk <= 1'b0;
            repeat (8) @(negedge sys_clk);
        end
        chipSelN <= 1'b1;
        serialDataIn <= 1'b0;
    endtask : spi_xfer
    task automatic cs_low(input int n);
        @(negedge sys_clk) chipSelN <= 1'b0;
        repeat (n) @(negedge sys_clk);
        chipSelN <= 1'b1;
    endtask : cs_low
endmodule : host_mcu_model
`default_nettype wire

// file: dv/lamp_switch_timing_supervisor_test.sv
// Purpose: self-checking bench
// Assumes: shortened counts, inputs changed on the falling clock edge
// Notes: host model drives serial and pwm clock
`timescale 1ns/100ps
`default_nettype none
module lamp_switch_timing_supervisor_test import lamp_timing_pkg::*; ;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] din = 4'h5;
    logic useExt = 1'b0;
    logic failsafeCfgIn = 1'b1;
    logic [3:0] otF = 4'h0, ocF = 4'h0, scF = 4'h0, uvF = 4'h0, outputCmd = 4'h0;
    logic [1:0] ocSel = 2'h0, cbSel = 2'h0;
    logic pwmEnable = 1'b0, clockSelect = 1'b0, ledMode = 1'b0;
    logic [3:0][7:0] pwmDuty = {4{DUTY_OFF}};
    logic [3:0] directCtrlIn, powerOutput, inputTimeout;
    logic chipSelN, serialClk, serialDataIn, extClk, faultFlagNOe, serialDataOe;
    logic spiWordStrobe, senseOutputValid, clockFail, watchdogExpired, openLoadStrobe, calibrated;
    logic [15:0] spiWord;
    int bad_count = 0, comparisons = 0, olCount = 0;
    int calLen[3] = '{1000, 6000, 3000};
    int cfHalf[4] = '{400, 200, 400, 0};
    assign directCtrlIn = {din[3:1], useExt ? extClk : din[0]};
    always #4 sys_clk = ~sys_clk;
    always @(negedge sys_clk) if (openLoadStrobe === 1'b1) olCount++;
    lamp_switch_timing_supervisor #(
        .TOGGLE_CYC(26'hC8), .WDOG_CYC(26'h12C), .CLKFAIL_LOW_CYC(17'h3E8),
        .SENSE_CYC(14'h32), .CAL_MAX(16'h1388)
    ) dut (
        .*, .overTemperatureFault(otF), .overCurrentFault(ocF), .shortCircuitFault(scF),
        .undervoltageFault(uvF), .overcurrentProfileSel(ocSel), .coolingProfileSel(cbSel),
        .faultFlagNOut(), .serialDataOut(), .ocStep(), .coolStep()
    );
    host_mcu_model host (.*);
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : cyc
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic report_and_stop();
        $display("comparisons=%0d mismatches=%0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : report_and_stop
    initial begin
        cyc(60000);
        bad_count++;
        report_and_stop();
    end
    initial begin
        cyc(8);
        check(16'({powerOutput, faultFlagNOe, serialDataOe, watchdogExpired}), 16'h0);
        rstn = 1'b1;
        cyc(250);
        check(16'({powerOutput, watchdogExpired, inputTimeout}), 16'h000F);
        cyc(70);
        check(16'({powerOutput, watchdogExpired}), 16'h000B);
        din = 4'h7;
        cyc(6);
        check(16'({powerOutput, inputTimeout}), 16'h007D);
        failsafeCfgIn = 1'b0;
        cyc(6);
        check(16'(watchdogExpired), 16'h0);
        host.spi_xfer(16'hA5C3, 16);
        cyc(8);
        check(spiWord, 16'hA5C3);
        check(16'(senseOutputValid), 16'h0);
        cyc(50);
        check(16'(senseOutputValid), 16'h1);
        host.spi_xfer(16'h3C5A, 8);
        cyc(8);
        check(spiWord, 16'hA5C3);
        foreach (calLen[i]) begin
            host.cs_low(calLen[i]);
            cyc(8);
            check(16'(calibrated), 16'(i == 2));
        end
        pwmEnable = 1'b1;
        clockSelect = 1'b1;
        for (int k = 0; k < 4; k++) begin
            ocSel = 2'(k);
            cbSel = 2'(k);
            pwmDuty = {4{DUTY_FULL}};
            cyc(12);
            check(16'(powerOutput), 16'hF);
            pwmDuty = {DUTY_OFF, DUTY_FULL, DUTY_OFF, DUTY_FULL};
            cyc(12);
            check(16'(powerOutput), 16'h5);
        end
        pwmDuty = {4{DUTY_FULL}};
        clockSelect = 1'b0;
        useExt = 1'b1;
        foreach (cfHalf[i]) begin
            host.halfPer <= cfHalf[i];
            cyc(3000);
            check(16'({clockFail, powerOutput & {4{clockFail}}}), 16'(i % 2) << 4);
        end
        clockSelect = 1'b1;
        cyc(8);
        check(16'(clockFail), 16'h0);
        pwmEnable = 1'b0;
        ledMode = 1'b1;
        host.halfPer <= 10;
        cyc(100);
        olCount = 0;
        cyc(2560);
        check(16'(olCount), 16'h1);
        useExt = 1'b0;
        outputCmd = 4'hF;
        cyc(10);
        check(16'(powerOutput), 16'hF);
        {otF, ocF, scF, uvF} = 16'h1248;
        cyc(600);
        check(16'({faultFlagNOe, powerOutput}), 16'h0F);
        cyc(40);
        check(16'({faultFlagNOe, powerOutput}), 16'h1F);
        cyc(840);
        check(16'({faultFlagNOe, powerOutput}), 16'h1F);
        cyc(40);
        check(16'({faultFlagNOe, powerOutput}), 16'h10);
        report_and_stop();
    end
endmodule : lamp_switch_timing_supervisor_test
`default_nettype wire
